// ### inc/fdcr_consts.vh
// constants of the floppy rate, status and diagnostic register bank
// assumes a plain 3-bit register port and one 20 MHz clock
// Contract
// - rate register bit 7 is software reset
// - rate register bit 6 selects power-down
// - bits 4:2 pick write shift steps
// - shift code 000 uses rate default delay
// - rate bits set speed and reduced current
// - tape 2 Mb/s needs rate 01, tape 10
// - latest rate write from either register wins
// - data port presents four-deep status stack
// - fifo disabled after reset, setup enables
// - term code 10 invalid, 11 ready change
// - status one error flags, unused bits zero
// - status two error flags, unused bit zero
// - at mode drives only inverted bit 7
// - second mode returns inverted change, density
// - third mode returns true change, flags
// - third mode stores no-shift flag only
`ifndef FDCR_CONSTS_VH
`define FDCR_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define FDCR_OFS_INT_STAT   3'h0
`define FDCR_OFS_INT_MASK   3'h1
`define FDCR_OFS_MODE_CFG   3'h2
`define FDCR_OFS_RATE       3'h4
`define FDCR_OFS_DATA       3'h5
`define FDCR_OFS_DIAG_CTL   3'h7
// ****************************************
// field positions
// ****************************************
`define FDCR_RATE_SWRST     7
`define FDCR_RATE_PWRDN     6
`define FDCR_SHIFT_HI       4
`define FDCR_SHIFT_LO       2
`define FDCR_CTL_NOSHIFT    2
`define FDCR_CFG_TAPE_HI    3
`define FDCR_CFG_TAPE_LO    2
`define FDCR_INT_RESULT     0
`define FDCR_INT_INVALID    1
`define FDCR_INT_ABORT      2
// ****************************************
// codes and reset values
// ****************************************
`define FDCR_MODE_AT        2'h0
`define FDCR_MODE_SECOND    2'h1
`define FDCR_MODE_THIRD     2'h2
`define FDCR_TERM_INVALID   2'h2
`define FDCR_TERM_READY_CHG 2'h3
`define FDCR_TAPE_2M        2'h2
`define FDCR_RATE_500K      2'h0
`define FDCR_RATE_300K      2'h1
`define FDCR_RATE_250K      2'h2
`define FDCR_RATE_1M        2'h3
`define FDCR_SHIFT_DEFAULT  3'h0
`define FDCR_SHIFT_OFF      3'h7
`define FDCR_DEF_STEPS_LOW  3'h3
`define FDCR_DEF_STEPS_FAST 3'h1
`define FDCR_RST_BYTE       8'h00
`define FDCR_STACK_DEPTH    4
// ****************************************
// shift step times, in picoseconds
// ****************************************
`define FDCR_STEP_DISK_PS   41670
`define FDCR_STEP_TAPE_PS   20800
`endif

// ### hw/fdcr_regs.v
// host register logic of the floppy controller: rate, data stack, diagnostics
// assumes ref_clk at 20 MHz, synchronous active-low reset, one-cycle strobes
`timescale 1ns/1ps
`include "fdcr_consts.vh"

module fdcr_regs (
    // clock and reset
    input  wire       ref_clk,
    input  wire       reset_n,
    // register port
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg  [7:0] reg_rdata_oe,
    // controller core: command path
    output reg  [7:0] cmd_byte,
    output reg        cmd_valid,
    input  wire       setup_cmd,
    input  wire       setup_fifo_en,
    output reg        fifo_enabled,
    // controller core: result load
    input  wire       res_load,
    input  wire [1:0] res_term_code,
    input  wire [5:0] res_zero_low,
    input  wire       flag_addr_mark,
    input  wire       flag_write_prot,
    input  wire       flag_no_sector,
    input  wire       flag_overrun,
    input  wire       flag_crc,
    input  wire       flag_end_track,
    input  wire       flag_data_mark,
    input  wire       flag_bad_cyl,
    input  wire       flag_scan_not,
    input  wire       flag_scan_hit,
    input  wire       flag_wrong_cyl,
    input  wire       flag_data_crc,
    input  wire       flag_ctrl_mark,
    input  wire [7:0] result_status_three,
    // drive side
    input  wire       media_changed,
    input  wire       dma_gate_mirror,
    // controls toward the core and drive
    output reg        soft_reset,
    output reg        power_down,
    output reg  [1:0] rate_select_bits,
    output reg        reduced_write_current,
    output reg        tape_2m_mode,
    output reg  [2:0] write_shift_steps,
    // interrupt
    output reg        irq
);

    // ****************************************
    // state
    // ****************************************
    // all storage clears on synchronous reset
    reg  [7:0] rate_r;           // rate register copy
    reg  [7:0] rate_nxt;
    reg  [1:0] eff_rate_r;       // effective rate select
    reg  [1:0] eff_rate_nxt;
    reg        no_shift_r;       // stored no-shift flag
    reg        no_shift_nxt;
    reg  [1:0] mode_r;           // diagnostic compatibility mode
    reg  [1:0] tape_sel_r;       // tape rate select
    reg        fifo_en_r;        // fifo enable from setup
    reg  [7:0] stack_r [0:3];    // result stack
    reg  [1:0] pop_idx_r;        // stack entry presented
    reg  [2:0] int_stat_r;       // sticky events
    reg  [2:0] int_stat_nxt;
    reg  [2:0] int_mask_r;       // event mask
    reg  [2:0] mc_sync_r;        // media change synchroniser
    reg        mc_filt_r;        // agreed media change level
    reg  [7:0] rd_nxt;           // read data next
    reg  [7:0] oe_nxt;           // read drive mask next
    reg  [2:0] steps_nxt;        // shift steps next
    wire [7:0] res0_w;
    wire [7:0] res1_w;
    wire [7:0] res2_w;
    wire       wr_rate;
    wire       wr_ctl;
    wire       rd_data;
    wire       dense_w;
    wire [2:0] shift_code;

    // ****************************************
    // decode
    // ****************************************
    // strobes qualified by offset
    assign wr_rate    = reg_wr && (reg_addr == `FDCR_OFS_RATE);
    assign wr_ctl     = reg_wr && (reg_addr == `FDCR_OFS_DIAG_CTL);
    assign rd_data    = reg_rd && (reg_addr == `FDCR_OFS_DATA);
    assign shift_code = rate_r[`FDCR_SHIFT_HI:`FDCR_SHIFT_LO];
    // high density when 500 kb/s or 1 Mb/s
    assign dense_w = (eff_rate_r == `FDCR_RATE_500K) || (eff_rate_r == `FDCR_RATE_1M);

    // ****************************************
    // result bytes
    // ****************************************
    // bytes built here, taken at load
    // status zero: termination code in the top bits
    assign res0_w = {res_term_code, res_zero_low};
    // status one: bits 6 and 3 unused, read zero
    assign res1_w = {flag_end_track, 1'b0, flag_crc, flag_overrun,
                    1'b0, flag_no_sector, flag_write_prot, flag_addr_mark};
    // status two: bit 7 unused, reads zero
    assign res2_w = {1'b0, flag_ctrl_mark, flag_data_crc, flag_wrong_cyl,
                    flag_scan_hit, flag_scan_not, flag_bad_cyl, flag_data_mark};

    // ****************************************
    // rate register and effective rate
    // ****************************************
    // latest write from either register sets the rate
    // control write sets rate in every mode
    // its upper bits ignored outside third mode
    always @* begin
        rate_nxt     = rate_r;
        eff_rate_nxt = eff_rate_r;
        no_shift_nxt = no_shift_r;
        if (wr_rate) begin
            rate_nxt     = reg_wdata;
            eff_rate_nxt = reg_wdata[1:0];
        end
        if (wr_ctl) begin
            eff_rate_nxt = reg_wdata[1:0];
            // flag only kept in third mode, no effect
            if (mode_r == `FDCR_MODE_THIRD) begin
                no_shift_nxt = reg_wdata[`FDCR_CTL_NOSHIFT];
            end
        end
    end

    // rate, config and no-shift storage
    // mode and tape select: own config register
    // writing it leaves the rate alone
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            rate_r     <= `FDCR_RST_BYTE;
            eff_rate_r <= `FDCR_RATE_500K;
            no_shift_r <= 1'b0;
            mode_r     <= `FDCR_MODE_AT;
            tape_sel_r <= 2'h0;
        end else begin
            rate_r     <= rate_nxt;
            eff_rate_r <= eff_rate_nxt;
            no_shift_r <= no_shift_nxt;
            if (reg_wr && (reg_addr == `FDCR_OFS_MODE_CFG)) begin
                mode_r     <= reg_wdata[1:0];
                tape_sel_r <= reg_wdata[`FDCR_CFG_TAPE_HI:`FDCR_CFG_TAPE_LO];
            end
        end
    end

    // ****************************************
    // write shift selection
    // ****************************************
    // steps of 41.67 ns, or 20.8 ns in tape mode
    // output is a step count, not a time
    // consumer picks step length by tape mode
    always @* begin
        case (shift_code)
            `FDCR_SHIFT_DEFAULT: begin
                // 125 ns below 1 Mb/s, one step at 1 and 2 Mb/s
                if (eff_rate_r == `FDCR_RATE_1M || tape_2m_mode) begin
                    steps_nxt = `FDCR_DEF_STEPS_FAST;
                end else begin
                    steps_nxt = `FDCR_DEF_STEPS_LOW;
                end
            end
            `FDCR_SHIFT_OFF: begin
                steps_nxt = 3'h0;
            end
            default: begin
                steps_nxt = shift_code;
            end
        endcase
    end

    // controls toward core and drive
    // these follow the stored copies: two edges
    // after the strobe; tape-dependent default
    // shift steps settle one edge later
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            soft_reset            <= 1'b0;
            power_down            <= 1'b0;
            rate_select_bits      <= `FDCR_RATE_500K;
            reduced_write_current <= 1'b1;
            tape_2m_mode          <= 1'b0;
            write_shift_steps     <= `FDCR_DEF_STEPS_LOW;
        end else begin
            soft_reset       <= rate_r[`FDCR_RATE_SWRST];
            power_down       <= rate_r[`FDCR_RATE_PWRDN];
            rate_select_bits <= eff_rate_r;
            // reduced current high for codes 00 and 11
            reduced_write_current <= (eff_rate_r == `FDCR_RATE_500K) ||
                                     (eff_rate_r == `FDCR_RATE_1M);
            // both settings needed for the tape rate
            tape_2m_mode <= (eff_rate_r == `FDCR_RATE_300K) &&
                            (tape_sel_r == `FDCR_TAPE_2M);
            write_shift_steps <= steps_nxt;
        end
    end

    // ****************************************
    // data port: command out, result stack
    // ****************************************
    // commands pass as one-cycle bytes, results pop
    // cmd_valid lasts one cycle, core takes it then
    // no second byte held back
    // load beats a same-cycle pop
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            cmd_byte  <= `FDCR_RST_BYTE;
            cmd_valid <= 1'b0;
            fifo_en_r <= 1'b0;
            pop_idx_r <= 2'h0;
        end else begin
            cmd_valid <= reg_wr && (reg_addr == `FDCR_OFS_DATA);
            if (reg_wr && (reg_addr == `FDCR_OFS_DATA)) begin
                cmd_byte <= reg_wdata;
            end
            // only the setup command changes fifo state
            if (setup_cmd) begin
                fifo_en_r <= setup_fifo_en;
            end
            // new load restarts at status zero
            if (res_load) begin
                pop_idx_r <= 2'h0;
            end else if (rd_data) begin
                pop_idx_r <= pop_idx_r + 2'h1;
            end
        end
    end

    // stack entries, one flop row per entry
    // whole bytes taken at the load pulse
    // flag inputs free to move afterwards
    genvar gi;
    generate
        for (gi = 0; gi < `FDCR_STACK_DEPTH; gi = gi + 1) begin : g_stack
            always @(posedge ref_clk) begin
                if (!reset_n) begin
                    stack_r[gi] <= `FDCR_RST_BYTE;
                end else if (res_load) begin
                    // entry order: status 0, 1, 2, 3
                    case (gi)
                        0:       stack_r[gi] <= res0_w;
                        1:       stack_r[gi] <= res1_w;
                        2:       stack_r[gi] <= res2_w;
                        default: stack_r[gi] <= result_status_three;
                    endcase
                end
            end
        end
    endgenerate

    // fifo state out
    // copy keeps the output on a flop
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            fifo_enabled <= 1'b0;
        end else begin
            fifo_enabled <= fifo_en_r;
        end
    end

    // ****************************************
    // media change synchroniser
    // ****************************************
    // three flops, level taken when last two agree
    // pin is unrelated to ref_clk; first flop
    // may go metastable, so only later two compared
    // glitches under two cycles filtered out
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            mc_sync_r <= 3'h0;
            mc_filt_r <= 1'b0;
        end else begin
            mc_sync_r <= {mc_sync_r[1:0], media_changed};
            if (mc_sync_r[1] == mc_sync_r[2]) begin
                mc_filt_r <= mc_sync_r[2];
            end
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // events set bits; write one clears; set wins
    // clear applied first, events after it,
    // so an event in its clear cycle survives
    always @* begin
        int_stat_nxt = int_stat_r;
        if (reg_wr && (reg_addr == `FDCR_OFS_INT_STAT)) begin
            int_stat_nxt = int_stat_r & ~reg_wdata[2:0];
        end
        if (res_load) begin
            int_stat_nxt[`FDCR_INT_RESULT] = 1'b1;
            if (res_term_code == `FDCR_TERM_INVALID) begin
                int_stat_nxt[`FDCR_INT_INVALID] = 1'b1;
            end
            if (res_term_code == `FDCR_TERM_READY_CHG) begin
                int_stat_nxt[`FDCR_INT_ABORT] = 1'b1;
            end
        end
    end

    // status, mask and interrupt line
    // irq from next status: one edge after event
    // mask change acts two edges after its write
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            int_stat_r <= 3'h0;
            int_mask_r <= 3'h0;
            irq        <= 1'b0;
        end else begin
            int_stat_r <= int_stat_nxt;
            if (reg_wr && (reg_addr == `FDCR_OFS_INT_MASK)) begin
                int_mask_r <= reg_wdata[2:0];
            end
            irq <= |(int_stat_nxt & int_mask_r);
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    // data one cycle after strobe; others zero
    // idle cycles give zero, all bits driven,
    // so no answer lingers past its cycle
    // reserved mode 3 reads like at mode
    always @* begin
        rd_nxt = `FDCR_RST_BYTE;
        oe_nxt = 8'hFF;
        if (reg_rd) begin
            case (reg_addr)
                `FDCR_OFS_INT_STAT: rd_nxt = {5'h00, int_stat_r};
                `FDCR_OFS_INT_MASK: rd_nxt = {5'h00, int_mask_r};
                `FDCR_OFS_MODE_CFG: rd_nxt = {4'h0, tape_sel_r, mode_r};
                `FDCR_OFS_DATA:     rd_nxt = stack_r[pop_idx_r];
                `FDCR_OFS_DIAG_CTL: begin
                    case (mode_r)
                        `FDCR_MODE_SECOND: begin
                            rd_nxt = {~mc_filt_r, 4'hF, eff_rate_r, ~dense_w};
                        end
                        `FDCR_MODE_THIRD: begin
                            rd_nxt = {mc_filt_r, 3'h7, dma_gate_mirror,
                                      no_shift_r, eff_rate_r};
                        end
                        default: begin
                            // only bit 7 driven, rest left floating
                            rd_nxt = {~mc_filt_r, 7'h00};
                            oe_nxt = 8'h80;
                        end
                    endcase
                end
                default: rd_nxt = `FDCR_RST_BYTE;
            endcase
        end
    end

    // registered read answer
    // answer stands one cycle after strobe
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata    <= `FDCR_RST_BYTE;
            reg_rdata_oe <= 8'hFF;
        end else begin
            reg_rdata    <= rd_nxt;
            reg_rdata_oe <= oe_nxt;
        end
    end

endmodule // fdcr_regs

// ### sim/fdcr_core_model.sv
// far-side model: controller core results, setup pulses and drive pins
// assumes its tasks are called by the bench right after a rising edge
`timescale 1ns/1ps

module fdcr_core_model (
    // clock
    input  wire       ref_clk,
    // result load toward the bank
    output reg        res_load      = 1'b0,
    output reg  [1:0] res_term_code = 2'h0,
    output reg  [5:0] res_zero_low  = 6'h00,
    output reg  [7:0] rs1           = 8'h00,
    output reg  [7:0] rs2           = 8'h00,
    output reg  [7:0] result_status_three = 8'h00,
    // setup command
    output reg        setup_cmd     = 1'b0,
    output reg        setup_fifo_en = 1'b0,
    // drive pins
    output reg        media_changed   = 1'b0,
    output reg        dma_gate_mirror = 1'b0
);
    // one result phase; flags turn over once the load has been taken
    task load(input [1:0] t, input [7:0] s1, input [7:0] s2); begin
        @(posedge ref_clk);
        res_term_code <= t;
        res_zero_low  <= 6'h05;
        rs1           <= s1;
        rs2           <= s2;
        result_status_three <= 8'h5A;
        res_load      <= 1'b1;
        @(posedge ref_clk);
        res_load      <= 1'b0;
        rs1           <= ~s1;
        rs2           <= ~s2;
    end endtask
    // setup command pulse carrying the fifo enable
    task setup(input en); begin
        @(posedge ref_clk);
        setup_cmd     <= 1'b1;
        setup_fifo_en <= en;
        @(posedge ref_clk);
        setup_cmd     <= 1'b0;
        setup_fifo_en <= ~en;
    end endtask
    // drive pin levels
    task pins(input m, input d); begin
        @(posedge ref_clk);
        media_changed   <= m;
        dma_gate_mirror <= d;
    end endtask
endmodule // fdcr_core_model

// ### sim/fdcr_regs_assertions.sv
// port checks of the rate, status and diagnostic register bank
// assumes the bind below reaches every fdcr_regs instance
`timescale 1ns/1ps
`include "fdcr_consts.vh"

module fdcr_regs_chk (
    // clock, reset, register port
    input wire       ref_clk,
    input wire       reset_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire [7:0] reg_rdata_oe,
    // core side
    input wire [7:0] cmd_byte,
    input wire       cmd_valid,
    input wire       setup_cmd,
    input wire       setup_fifo_en,
    input wire       fifo_enabled,
    // controls
    input wire       soft_reset,
    input wire       power_down,
    input wire [1:0] rate_select_bits,
    input wire       reduced_write_current,
    input wire       tape_2m_mode,
    input wire [2:0] write_shift_steps
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // rate register control bits
    property p_rate_ctl;
        reg_wr && reg_addr == `FDCR_OFS_RATE |=> ##1 soft_reset == $past(reg_wdata[7], 2)
            && power_down == $past(reg_wdata[6], 2);
    endproperty
    a_rate_ctl: assert property (p_rate_ctl) else $error("rate control bits wrong");
    // latest rate write wins
    property p_rate_last;
        reg_wr && (reg_addr == `FDCR_OFS_RATE || reg_addr == `FDCR_OFS_DIAG_CTL)
            |=> ##1 rate_select_bits == $past(reg_wdata[1:0], 2);
    endproperty
    a_rate_last: assert property (p_rate_last) else $error("rate not latest");
    // reduced current follows the rate
    property p_rdc;
        reduced_write_current == (rate_select_bits == 2'h0 || rate_select_bits == 2'h3);
    endproperty
    a_rdc: assert property (p_rdc) else $error("reduced current wrong");
    // tape rate only with rate code 01
    property p_tape;
        tape_2m_mode |-> rate_select_bits == 2'h1;
    endproperty
    a_tape: assert property (p_tape) else $error("tape rate wrong");
    // shift disabled by code 111
    property p_shift_off;
        reg_wr && reg_addr == `FDCR_OFS_RATE && reg_wdata[4:2] == 3'h7
            |-> ##[1:2] write_shift_steps == 3'h0;
    endproperty
    a_shift_off: assert property (p_shift_off) else $error("shift not off");
    // read data only in the answer cycle
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00 && reg_rdata_oe == 8'hFF;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
    // data port write gives one command byte
    property p_cmd;
        reg_wr && reg_addr == `FDCR_OFS_DATA |=> cmd_valid && cmd_byte == $past(reg_wdata);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command byte wrong");
    // setup sets the fifo state two cycles on
    property p_fifo;
        setup_cmd |-> ##2 fifo_enabled == $past(setup_fifo_en, 2);
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo state wrong");
    // reset leaves power-down and soft reset low
    property p_rst;
        $rose(reset_n) |-> !power_down && !soft_reset;
    endproperty
    a_rst: assert property (p_rst) else $error("control bits after reset");
    cp_oe: cover property (reg_rdata_oe == 8'h80);
    cp_tape: cover property (tape_2m_mode);
    cp_fifo: cover property (fifo_enabled);
endmodule // fdcr_regs_chk

bind fdcr_regs fdcr_regs_chk chk_u (.*);

// ### sim/tb_top.sv
// self-checking bench of the rate, status and diagnostic register bank
// assumes the core model beside the design and the bound checker
`timescale 1ns/1ps
`include "fdcr_consts.vh"
`define CHK(g, e) begin #1; samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
    // ****************************************
    // signals
    // ****************************************
    localparam [2:0] RT = `FDCR_OFS_RATE;    // rate register
    localparam [2:0] DG = `FDCR_OFS_DIAG_CTL; // diag and config control
    localparam [2:0] DP = `FDCR_OFS_DATA;    // data port
    localparam [31:0] EXP = 32'hC5B77F5A;    // first result stack
    reg        ref_clk   = 1'b0;
    reg        reset_n   = 1'b0;
    reg  [2:0] reg_addr  = 3'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr    = 1'b0;
    reg        reg_rd    = 1'b0;
    wire [7:0] reg_rdata, reg_rdata_oe, cmd_byte, rs1, rs2, result_status_three;
    wire [5:0] res_zero_low;
    wire [2:0] write_shift_steps;
    wire [1:0] rate_select_bits, res_term_code;
    wire cmd_valid, setup_cmd, setup_fifo_en, fifo_enabled, res_load, media_changed;
    wire dma_gate_mirror, soft_reset, power_down, reduced_write_current, tape_2m_mode, irq;
    integer mismatches = 0;
    integer samples_checked = 0;
    integer i;
    reg  [7:0] rv;  // last read byte
    reg  [7:0] ro;  // last read drive enable
    always #25 ref_clk = ~ref_clk;
    fdcr_regs dut_u (.*, .flag_addr_mark(rs1[0]), .flag_write_prot(rs1[1]),
        .flag_no_sector(rs1[2]), .flag_overrun(rs1[4]), .flag_crc(rs1[5]),
        .flag_end_track(rs1[7]), .flag_data_mark(rs2[0]), .flag_bad_cyl(rs2[1]),
        .flag_scan_not(rs2[2]), .flag_scan_hit(rs2[3]), .flag_wrong_cyl(rs2[4]),
        .flag_data_crc(rs2[5]), .flag_ctrl_mark(rs2[6]));
    fdcr_core_model core_u (.*);
    // ****************************************
    // bus tasks
    // ****************************************
    task wt(input integer n); repeat (n) @(posedge ref_clk); endtask
    task wr(input [2:0] a, input [7:0] d); begin
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    end endtask
    task rd(input [2:0] a); begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 rv = reg_rdata;
        ro = reg_rdata_oe;
    end endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset; begin
        @(posedge ref_clk);
        reset_n <= 1'b0;
        wt(10);
        reset_n <= 1'b1;
        `CHK({soft_reset, power_down, rate_select_bits, reduced_write_current}, 5'h01)
        `CHK({write_shift_steps, fifo_enabled, irq, tape_2m_mode}, 6'h18)
    end endtask
    task t_rate; begin
        for (i = 0; i < 4; i = i + 1) begin
            wr(RT, i[7:0]);
            wt(2);
            `CHK({reduced_write_current, rate_select_bits}, {i == 0 || i == 3, i[1:0]})
            `CHK(write_shift_steps, (i == 3) ? 3'h1 : 3'h3)
        end
        for (i = 1; i < 8; i = i + 1) begin
            wr(RT, {3'h0, i[2:0], 2'h2});
            wt(2);
            `CHK(write_shift_steps, (i == 7) ? 3'h0 : i[2:0])
        end
        wr(RT, 8'hC2);
        wt(1);
        `CHK({soft_reset, power_down}, 2'h3)
        wr(RT, 8'h02);
        wt(1);
        `CHK({soft_reset, power_down}, 2'h0)
        wr(DG, 8'h03);
        wr(RT, 8'h02);
        wt(1);
        `CHK(rate_select_bits, 2'h2)
        wr(DG, 8'h01);
        wt(1);
        `CHK(rate_select_bits, 2'h1)
        wr(`FDCR_OFS_MODE_CFG, 8'h08);
        wr(RT, 8'h01);
        wt(2);
        `CHK({tape_2m_mode, write_shift_steps}, 4'h9)
        wr(RT, 8'h02);
        wt(2);
        `CHK({tape_2m_mode, write_shift_steps}, 4'h3)
    end endtask
    task t_diag; begin
        wr(`FDCR_OFS_MODE_CFG, 8'h00);
        core_u.pins(1'b1, 1'b0);
        wt(6);
        rd(DG);
        `CHK({ro, rv[7]}, 9'h100)
        wr(`FDCR_OFS_MODE_CFG, 8'h01);
        wr(DG, 8'h02);
        core_u.pins(1'b0, 1'b1);
        wt(6);
        rd(DG);
        `CHK({ro, rv}, 16'hFFFD)
        wr(`FDCR_OFS_MODE_CFG, 8'h02);
        wr(DG, 8'h05);
        core_u.pins(1'b1, 1'b1);
        wt(6);
        rd(DG);
        `CHK(rv, 8'hFD)
        wr(DG, 8'h01);
        rd(DG);
        `CHK(rv, 8'hF9)
    end endtask
    task t_data; begin
        wr(`FDCR_OFS_INT_MASK, 8'h00);
        core_u.load(`FDCR_TERM_READY_CHG, 8'hFF, 8'hFF);
        rd(`FDCR_OFS_INT_STAT);
        `CHK({irq, rv}, 9'h005)
        for (i = 0; i < 5; i = i + 1) begin
            rd(DP);
            `CHK(rv, EXP[31 - 8 * (i % 4) -: 8])
        end
        wr(`FDCR_OFS_INT_MASK, 8'h04);
        wt(2);
        `CHK(irq, 1'b1)
        wr(`FDCR_OFS_INT_STAT, 8'h04);
        rd(`FDCR_OFS_INT_STAT);
        `CHK({irq, rv}, 9'h001)
        core_u.load(`FDCR_TERM_INVALID, 8'h00, 8'h00);
        rd(DP);
        `CHK(rv, 8'h85)
        rd(DP);
        `CHK(rv, 8'h00)
        wr(`FDCR_OFS_INT_MASK, 8'h02);
        rd(`FDCR_OFS_INT_STAT);
        `CHK({irq, rv}, 9'h103)
        wr(`FDCR_OFS_INT_STAT, 8'h07);
        rd(3'h3);
        `CHK({irq, rv}, 9'h000)
    end endtask
    task t_setup; begin
        wr(DP, 8'h3C);
        `CHK(cmd_valid, 1'b1)
        wt(1);
        `CHK({cmd_valid, cmd_byte}, 9'h03C)
        core_u.setup(1'b1);
        wt(2);
        `CHK(fifo_enabled, 1'b1)
        core_u.setup(1'b0);
        wt(2);
        `CHK(fifo_enabled, 1'b0)
    end endtask
    task t_reset_again; begin
        core_u.setup(1'b1);
        wr(DG, 8'h05);
        wr(RT, 8'hC1);
        t_reset;
        wr(`FDCR_OFS_MODE_CFG, 8'h02);
        wt(4);
        rd(DG);
        `CHK(rv, 8'hF8)
    end endtask
    // ****************************************
    // sequence, watchdog and verdict
    // ****************************************
    initial begin
        t_reset;
        t_rate;
        t_diag;
        t_data;
        t_setup;
        t_reset_again;
        report_and_stop;
    end
    initial begin
        #200000;
        mismatches++;
        report_and_stop;
    end
    task report_and_stop; begin
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end endtask
endmodule // tb_top
